// ---- design/gns_pkg.sv ----
// Package: constants, map layout and carrier types for node supervision
package gns_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int NODES = 8;
    localparam int EMCY_DEPTH = 10;
    localparam int IMG_BYTES = 64;
    localparam int SDO_DATA = 4;
    localparam int SDO_REC = 7 + SDO_DATA;

    // Register byte addresses
    localparam logic [7:0] REG_MAP0 = 8'h00;
    localparam logic [7:0] REG_MAP1 = 8'h04;
    localparam logic [7:0] REG_ERR = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_GCFG0 = 8'h20;

    // Map bytes: enable bit and six-bit byte position
    localparam int MAP_EN_BIT = 7;
    localparam int MAP0_GUARD_LSB = 0;
    localparam int MAP0_EDATA_LSB = 8;
    localparam int MAP0_ECNT_LSB = 16;
    localparam int MAP0_ENODE_LSB = 24;
    localparam int MAP1_ERR_LSB = 0;
    localparam int MAP1_CTRL_LSB = 8;
    localparam int MAP1_SDOIN_LSB = 16;
    localparam int MAP1_SDOOUT_LSB = 24;
    localparam logic [31:0] MAP_RESET = 32'h0000_0000;

    // Guard config word
    localparam int GCFG_EN_BIT = 0;
    localparam int GCFG_LIFE_LSB = 8;
    localparam int GCFG_IVL_LSB = 16;
    localparam logic [31:0] GCFG_RESET = 32'h0000_0000;

    // Error byte: bit 0 is hardware overflow flag
    localparam int ERR_OVF_BIT = 0;
    localparam int STAT_CNT_LSB = 8;
    localparam int STAT_BUSY_BIT = 16;

    localparam int CTRL_EMCY_BIT = 7;
    localparam int CTRL_OP_BIT = 6;
    localparam int CTRL_RTR_BIT = 5;

    // Record byte positions
    localparam int REC_IDX_HI = 0;
    localparam int REC_IDX_LO = 1;
    localparam int REC_SUB = 2;
    localparam int REC_CMD = 3;
    localparam int REC_JOB = 4;
    localparam int REC_NODE = 5;
    localparam int REC_LEN = 6;
    localparam int REC_DATA = 7;
    localparam logic [7:0] SDO_ST_OK = 8'h00;
    localparam logic [7:0] SDO_ST_BUSY = 8'h01;

    typedef struct packed {
        logic [6:0] node;
        logic [63:0] data;
    } gns_emcy_s;

    typedef struct packed {
        logic [15:0] index;
        logic [7:0] sub;
        logic [7:0] cmd;
        logic [7:0] job;
        logic [7:0] node;
        logic [7:0] len;
        logic [31:0] data;
    } gns_sdo_req_s;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] len;
        logic [31:0] data;
    } gns_sdo_rsp_s;
endpackage

// ---- design/gns_emcy_queue.sv ----
// Emergency message queue with occupancy count
`timescale 1ns/1ns
`default_nettype none
module gns_emcy_queue
    import gns_pkg::*;
#(
    parameter int DEPTH = EMCY_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic push,
    input var gns_emcy_s push_msg,
    input wire logic pop,
    output var gns_emcy_s head,
    output logic [3:0] count,
    output logic full
);
    gns_emcy_s mem [DEPTH];
    logic [3:0] wr_ptr;
    logic [3:0] rd_ptr;
    logic do_push;
    logic do_pop;

    // Full queue drops new messages
    assign do_push = push && (count != 4'(DEPTH));
    assign do_pop = pop && (count != 4'h0);
    assign full = (count == 4'(DEPTH));
    assign head = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_msg;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count <= 4'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == 4'(DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == 4'(DEPTH - 1)) ? 4'h0 : rd_ptr + 4'h1;
            end
            count <= count + 4'(do_push) - 4'(do_pop);
        end
    end
endmodule // gns_emcy_queue
`default_nettype wire

// ---- design/gns_supervisor.sv ----
// Gateway node supervision: guarding, emergencies, control, SDO window
`timescale 1ns/1ns
`default_nettype none
module gns_supervisor
    import gns_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fb_out_valid,
    input wire logic [IMG_BYTES*8-1:0] fb_out_image,
    output logic [IMG_BYTES*8-1:0] fb_in_image,
    output logic guard_req_valid,
    output logic [6:0] guard_req_node,
    input wire logic guard_rsp_valid,
    input wire logic [6:0] guard_rsp_node,
    input wire logic emcy_valid,
    input var gns_emcy_s emcy_msg,
    output logic nmt_start_operational,
    output logic rtr_all_rx_pdo,
    output logic sdo_req_valid,
    output var gns_sdo_req_s sdo_req,
    input wire logic sdo_done,
    input var gns_sdo_rsp_s sdo_result
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] get_byte(
        input logic [IMG_BYTES*8-1:0] img, input int idx);
        get_byte = (idx < IMG_BYTES) ? img[idx*8 +: 8] : 8'h00;
    endfunction

    function automatic logic in_win(input logic [7:0] m, input int b,
        input int len);
        in_win = m[MAP_EN_BIT] && (b >= int'(m[5:0]))
            && (b < int'(m[5:0]) + len);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        for (int k = 0; k < 4; k++) begin
            merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
        end
    endfunction

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] map0;
    logic [31:0] map1;
    logic [7:1] err_sw;
    logic err_ovf;
    logic [31:0] gcfg [NODES];
    logic [NODES-1:0] guard_ok;
    logic [3:0] emcy_count;
    logic sdo_busy;
    logic [31:0] next_readdata;
    logic acc_wr;

    assign acc_wr = avs_write && !avs_waitrequest;

    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (avs_address)
            REG_MAP0: next_readdata = map0;
            REG_MAP1: next_readdata = map1;
            REG_ERR: next_readdata = {24'h00_0000, err_sw, err_ovf};
            REG_STATUS: next_readdata = {15'h0000, sdo_busy, 4'h0,
                emcy_count, guard_ok};
            default: begin
                for (int i = 0; i < NODES; i++) begin
                    if (avs_address == REG_GCFG0 + 8'(4 * i)) begin
                        next_readdata = gcfg[i];
                    end
                end
            end
        endcase
    end

    // One wait state: answer on the second cycle of every request
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            map0 <= MAP_RESET;
            map1 <= MAP_RESET;
            err_sw <= 7'h00;
        end else if (acc_wr) begin
            if (avs_address == REG_MAP0) begin
                map0 <= merge(map0, avs_writedata, avs_byteenable);
            end
            if (avs_address == REG_MAP1) begin
                map1 <= merge(map1, avs_writedata, avs_byteenable);
            end
            if (avs_address == REG_ERR && avs_byteenable[0]) begin
                err_sw <= avs_writedata[7:1];
            end
        end
    end

    // ------------------------------------------------------------
    // Node guarding
    // ------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic ms_tick;
    logic [NODES-1:0] pend;
    logic [NODES-1:0] gnt;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tick_cnt <= 32'h0000_0000;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000
                : tick_cnt + 32'h0000_0001;
        end
    end

    // Lowest pending node wins; one request per cycle
    always_comb begin
        gnt = '0;
        for (int i = NODES - 1; i >= 0; i--) begin
            if (pend[i]) begin
                gnt = '0;
                gnt[i] = 1'b1;
            end
        end
    end

    for (genvar i = 0; i < NODES; i++) begin : g_node
        logic [15:0] ms_cnt;
        logic [7:0] miss;
        logic waiting;
        logic alive;
        logic elapse;
        logic rsp_hit;
        logic [7:0] life;
        logic [15:0] ivl;

        assign life = gcfg[i][GCFG_LIFE_LSB +: 8];
        assign ivl = gcfg[i][GCFG_IVL_LSB +: 16];
        assign elapse = ms_tick
            && ({1'b0, ms_cnt} + 17'h0_0001 >= {1'b0, ivl});
        assign rsp_hit = guard_rsp_valid && (guard_rsp_node == 7'(i + 1));

        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                gcfg[i] <= GCFG_RESET;
            end else if (acc_wr && avs_address == REG_GCFG0 + 8'(4 * i)) begin
                gcfg[i] <= merge(gcfg[i], avs_writedata, avs_byteenable);
            end
        end

        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                ms_cnt <= 16'h0000;
                miss <= 8'h00;
                waiting <= 1'b0;
                alive <= 1'b0;
                pend[i] <= 1'b0;
            end else if (!gcfg[i][GCFG_EN_BIT]) begin
                ms_cnt <= 16'h0000;
                miss <= 8'h00;
                waiting <= 1'b0;
                alive <= 1'b0;
                pend[i] <= 1'b0;
            end else begin
                if (ms_tick) begin
                    ms_cnt <= elapse ? 16'h0000 : ms_cnt + 16'h0001;
                end
                pend[i] <= (pend[i] && !gnt[i]) || elapse;
                if (rsp_hit) begin
                    miss <= 8'h00;
                    alive <= 1'b1;
                end else if (elapse && waiting) begin
                    miss <= miss + 8'h01;
                    if ({1'b0, miss} + 9'h001 >= {1'b0, life}) begin
                        alive <= 1'b0;
                    end
                end
                waiting <= gnt[i] || (waiting && !rsp_hit);
            end
        end

        assign guard_ok[i] = gcfg[i][GCFG_EN_BIT] && alive;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            guard_req_valid <= 1'b0;
            guard_req_node <= 7'h00;
        end else begin
            guard_req_valid <= |gnt;
            for (int i = 0; i < NODES; i++) begin
                if (gnt[i]) begin
                    guard_req_node <= 7'(i + 1);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Emergency queue and control byte
    // ------------------------------------------------------------
    gns_emcy_s emcy_head;
    gns_emcy_s emcy_cur;
    logic emcy_push;
    logic emcy_full;
    logic emcy_pop;
    logic [7:0] ctrl_now;
    logic [7:0] ctrl_prev;
    logic ctrl_take;

    // Only nodes with guarding enabled may queue
    always_comb begin
        emcy_push = 1'b0;
        for (int i = 0; i < NODES; i++) begin
            if (emcy_valid && emcy_msg.node == 7'(i + 1)
                && gcfg[i][GCFG_EN_BIT]) begin
                emcy_push = 1'b1;
            end
        end
    end

    assign ctrl_take = fb_out_valid
        && map1[MAP1_CTRL_LSB + MAP_EN_BIT];
    assign ctrl_now = get_byte(fb_out_image,
        int'(map1[MAP1_CTRL_LSB +: 6]));
    assign emcy_pop = ctrl_take
        && (ctrl_now[CTRL_EMCY_BIT] != ctrl_prev[CTRL_EMCY_BIT]);

    gns_emcy_queue #(.DEPTH(EMCY_DEPTH)) u_queue (
        .core_clk(core_clk),
        .reset(reset),
        .push(emcy_push),
        .push_msg(emcy_msg),
        .pop(emcy_pop),
        .head(emcy_head),
        .count(emcy_count),
        .full(emcy_full)
    );

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_prev <= 8'h00;
            emcy_cur <= '0;
            nmt_start_operational <= 1'b0;
            rtr_all_rx_pdo <= 1'b0;
        end else begin
            nmt_start_operational <= ctrl_take && (ctrl_now[CTRL_OP_BIT]
                != ctrl_prev[CTRL_OP_BIT]);
            rtr_all_rx_pdo <= ctrl_take && ctrl_now[CTRL_RTR_BIT]
                && !ctrl_prev[CTRL_RTR_BIT];
            if (ctrl_take) begin
                ctrl_prev <= ctrl_now;
            end
            // Empty queue leaves current message in place
            if (emcy_pop && emcy_count != 4'h0) begin
                emcy_cur <= emcy_head;
            end
        end
    end

    // Overflow flag: set wins over a software clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            err_ovf <= 1'b0;
        end else begin
            err_ovf <= (emcy_push && emcy_full) || (err_ovf && !(acc_wr
                && avs_address == REG_ERR && avs_byteenable[0]
                && avs_writedata[ERR_OVF_BIT]));
        end
    end

    // ------------------------------------------------------------
    // SDO window
    // ------------------------------------------------------------
    logic [7:0] req_b [SDO_REC];
    logic [7:0] rsp_b [SDO_REC];
    logic [7:0] rsp_job;
    gns_sdo_rsp_s rsp;
    logic sdo_start;
    logic [7:0] got_len;

    always_comb begin
        for (int k = 0; k < SDO_REC; k++) begin
            req_b[k] = get_byte(fb_out_image,
                int'(map1[MAP1_SDOIN_LSB +: 6]) + k);
        end
    end

    // New job number in the request window starts a transfer
    assign sdo_start = fb_out_valid && !sdo_busy
        && map1[MAP1_SDOIN_LSB + MAP_EN_BIT]
        && map1[MAP1_SDOOUT_LSB + MAP_EN_BIT]
        && (req_b[REC_JOB] != rsp_job);
    assign got_len = (sdo_result.len < sdo_req.len) ? sdo_result.len
        : sdo_req.len;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sdo_busy <= 1'b0;
            sdo_req_valid <= 1'b0;
            sdo_req <= '0;
            rsp <= '0;
            rsp_job <= 8'h00;
        end else begin
            sdo_req_valid <= sdo_start;
            if (sdo_start) begin
                sdo_busy <= 1'b1;
                sdo_req <= {req_b[REC_IDX_HI], req_b[REC_IDX_LO],
                    req_b[REC_SUB], req_b[REC_CMD], req_b[REC_JOB],
                    req_b[REC_NODE], req_b[REC_LEN], req_b[REC_DATA],
                    req_b[REC_DATA + 1], req_b[REC_DATA + 2],
                    req_b[REC_DATA + 3]};
                rsp.status <= SDO_ST_BUSY;
            end else if (sdo_busy && sdo_done) begin
                sdo_busy <= 1'b0;
                rsp.status <= sdo_result.status;
                rsp.len <= got_len;
                for (int k = 0; k < SDO_DATA; k++) begin
                    rsp.data[31 - 8*k -: 8] <= (8'(k) < got_len)
                        ? sdo_result.data[31 - 8*k -: 8] : 8'h00;
                end
                rsp_job <= sdo_req.job;
            end
        end
    end

    always_comb begin
        rsp_b[REC_IDX_HI] = sdo_req.index[15:8];
        rsp_b[REC_IDX_LO] = sdo_req.index[7:0];
        rsp_b[REC_SUB] = sdo_req.sub;
        rsp_b[REC_CMD] = rsp.status;
        rsp_b[REC_JOB] = rsp_job;
        rsp_b[REC_NODE] = sdo_req.node;
        rsp_b[REC_LEN] = rsp.len;
        for (int k = 0; k < SDO_DATA; k++) begin
            rsp_b[REC_DATA + k] = rsp.data[31 - 8*k -: 8];
        end
    end

    // ------------------------------------------------------------
    // Fieldbus input image
    // ------------------------------------------------------------
    // Overlapping windows: later source in this list wins
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fb_in_image <= '0;
        end else begin
            for (int b = 0; b < IMG_BYTES; b++) begin
                fb_in_image[b*8 +: 8] <= 8'h00;
                if (in_win(map0[MAP0_GUARD_LSB +: 8], b, 1)) begin
                    fb_in_image[b*8 +: 8] <= 8'(guard_ok);
                end
                if (in_win(map0[MAP0_EDATA_LSB +: 8], b, 8)) begin
                    fb_in_image[b*8 +: 8] <= emcy_cur.data[8*(b
                        - int'(map0[MAP0_EDATA_LSB +: 6])) +: 8];
                end
                if (in_win(map0[MAP0_ECNT_LSB +: 8], b, 1)) begin
                    fb_in_image[b*8 +: 8] <= {4'h0, emcy_count};
                end
                if (in_win(map0[MAP0_ENODE_LSB +: 8], b, 1)) begin
                    fb_in_image[b*8 +: 8] <= {1'b0, emcy_cur.node};
                end
                if (in_win(map1[MAP1_ERR_LSB +: 8], b, 1)) begin
                    fb_in_image[b*8 +: 8] <= {err_sw, err_ovf};
                end
                if (in_win(map1[MAP1_SDOOUT_LSB +: 8], b, SDO_REC)) begin
                    fb_in_image[b*8 +: 8] <= rsp_b[b
                        - int'(map1[MAP1_SDOOUT_LSB +: 6])];
                end
            end
        end
    end
endmodule // gns_supervisor
`default_nettype wire

// ---- verif/gns_supervisor_monitor.sv ----
// Port checker for the node supervision block
`timescale 1ns/1ns
`default_nettype none
module gns_supervisor_monitor
    import gns_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic fb_out_valid,
    input wire logic guard_req_valid,
    input wire logic [6:0] guard_req_node,
    input wire logic nmt_start_operational,
    input wire logic rtr_all_rx_pdo,
    input wire logic sdo_req_valid,
    input var gns_sdo_req_s sdo_req
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wait_ans_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer held too long");
    guard_node_a: assert property (
        guard_req_valid |-> guard_req_node inside {[7'h01:7'h08]})
        else $error("guard request to bad node");
    nmt_cause_a: assert property (
        nmt_start_operational |-> $past(fb_out_valid))
        else $error("start command without new image");
    rtr_cause_a: assert property (
        rtr_all_rx_pdo |-> $past(fb_out_valid))
        else $error("remote request without new image");
    rtr_once_a: assert property (
        rtr_all_rx_pdo |=> !rtr_all_rx_pdo)
        else $error("remote request repeated");
    sdo_cause_a: assert property (
        sdo_req_valid |-> $past(fb_out_valid))
        else $error("transfer started without image");
    sdo_hold_a: assert property (
        !sdo_req_valid |-> $stable(sdo_req))
        else $error("transfer request changed while idle");
endmodule // gns_supervisor_monitor
bind gns_supervisor gns_supervisor_monitor gns_supervisor_monitor_inst (.*);
`default_nettype wire

// ---- verif/gns_partner.sv ----
// Slave-side model: guard answers and transfer replies
`timescale 1ns/1ns
`default_nettype none
module gns_partner
    import gns_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] alive,
    input wire logic guard_req_valid,
    input wire logic [6:0] guard_req_node,
    output logic guard_rsp_valid,
    output logic [6:0] guard_rsp_node,
    input wire logic sdo_req_valid,
    output logic sdo_done,
    output var gns_sdo_rsp_s sdo_result
);
    logic [3:0] wait_cnt;
    logic [7:0] quiet;
    // Gap since the last guard request; a long one means master lost
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            quiet <= 8'h00;
        end else if (guard_req_valid) begin
            quiet <= 8'h00;
        end else if (quiet != 8'hFF) begin
            quiet <= quiet + 8'h01;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            guard_rsp_valid <= 1'b0;
            guard_rsp_node <= 7'h00;
        end else if (guard_req_valid
            && alive[guard_req_node[2:0] - 3'h1]) begin
            guard_rsp_valid <= 1'b1;
            guard_rsp_node <= guard_req_node;
        end else begin
            guard_rsp_valid <= 1'b0;
            guard_rsp_node <= ~guard_rsp_node; // Idle: id inverted every cycle, not cleared
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wait_cnt <= 4'h0;
            sdo_done <= 1'b0;
            sdo_result <= '0;
        end else begin
            sdo_done <= (wait_cnt == 4'h1);
            if (sdo_req_valid) begin
                wait_cnt <= 4'h6;
            end else if (wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
            // Slow reply so the busy status shows; three bytes come back
            sdo_result <= (wait_cnt == 4'h1) ?
                {8'h00, 8'h03, 32'hAABBCC00} : ~sdo_result;
        end
    end
endmodule // gns_partner
`default_nettype wire

// ---- verif/gns_supervisor_tb_top.sv ----
// Self-checking bench for the node supervision block
`timescale 1ns/1ns
`default_nettype none
module gns_supervisor_tb_top;
    import gns_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1;
    logic [7:0] avs_address = 8'h00, alive = 8'h00;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic fb_out_valid = 1'b0, emcy_valid = 1'b0;
    logic [IMG_BYTES*8-1:0] fb_out_image = '0, fb_in_image, img = '0;
    logic guard_req_valid, guard_rsp_valid, nmt_start_operational;
    logic [6:0] guard_req_node, guard_rsp_node;
    logic rtr_all_rx_pdo, sdo_req_valid, sdo_done;
    gns_emcy_s emcy_msg = '0;
    gns_sdo_req_s sdo_req;
    gns_sdo_rsp_s sdo_result;
    int cyc = 0, n_nmt = 0, n_rtr = 0, bad_count = 0, cmp_count = 0;
    gns_supervisor #(.TICK_CYCLES(10)) gns_supervisor_inst (.*);
    gns_partner gns_partner_inst (.*);
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (!reset && nmt_start_operational !== 1'b0) n_nmt <= n_nmt + 1;
        if (!reset && rtr_all_rx_pdo !== 1'b0) n_rtr <= n_rtr + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            final_report();
        end
    end
    task automatic final_report();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] ib(input int p);
        return fb_in_image[8*p+:8];
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic send();
        @(posedge core_clk);
        fb_out_image <= img;
        fb_out_valid <= 1'b1;
        @(posedge core_clk);
        fb_out_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic push(input logic [6:0] n, input logic [7:0] b);
        @(posedge core_clk);
        emcy_valid <= 1'b1;
        emcy_msg <= {n, {8{b}}};
        @(posedge core_clk);
        emcy_valid <= 1'b0;
    endtask
    task automatic guard_test();
        logic [31:0] r;
        rd(REG_STATUS, r);
        chk(r[7:0], 8'h00);
        wr(REG_MAP0, 32'h8483_8882);
        wr(REG_GCFG0, 32'h0001_0201);
        wr(REG_GCFG0 + 8'h04, 32'h0001_0201);
        alive <= 8'h02;
        repeat (100) @(posedge core_clk);
        chk(ib(2), 8'h02);
        chk(gns_partner_inst.quiet < 8'h14, 1'b1);
        rd(REG_STATUS, r);
        chk(r[7:0], 8'h02);
        alive <= 8'h00;
        repeat (100) @(posedge core_clk);
        chk(ib(2), 8'h00);
    endtask
    task automatic emcy_test();
        logic [31:0] r;
        push(7'h05, 8'h77); // Node not guarded: dropped
        for (int k = 1; k <= 11; k++) push(7'h02, 8'(k));
        repeat (2) @(posedge core_clk);
        rd(REG_STATUS, r);
        chk(r[11:8], 4'hA);
        rd(REG_ERR, r);
        chk(r[0], 1'b1);
        chk(ib(3), 8'h0A);
    endtask
    task automatic ctrl_test();
        wr(REG_MAP1, 32'hA090_0081);
        img[7:0] = 8'hC0;
        send();
        chk(n_nmt, 0);
        wr(REG_MAP1, 32'hA090_8081);
        img[7:0] = 8'h80;
        send();
        chk(ib(3), 8'h09);
        chk(ib(8), 8'h01);
        chk(ib(4), 8'h02);
        chk(ib(1), 8'h01);
        wr(REG_ERR, 32'h0000_00A1);
        img[7:0] = 8'hC0;
        send();
        img[7:0] = 8'hE0;
        send();
        send();
        img[7:0] = 8'h60;
        send();
        chk(n_nmt, 1);
        chk(n_rtr, 1);
        chk(ib(3), 8'h08);
        chk(ib(1), 8'hA0);
    endtask
    task automatic sdo_test();
        img[128+:56] = 56'h02_0501_0100_0910;
        send();
        chk(sdo_req.index, 16'h1009);
        chk(ib(35), SDO_ST_BUSY);
        repeat (10) @(posedge core_clk);
        chk(ib(32), 8'h10);
        chk(ib(35), SDO_ST_OK);
        chk(ib(36), 8'h01);
        chk({ib(38), ib(39), ib(40), ib(41)}, 32'h02AABB00);
        img[160+:8] = 8'h02;
        img[176+:8] = 8'h04;
        send();
        repeat (10) @(posedge core_clk);
        chk({ib(36), ib(38), ib(41)}, 24'h0203CC);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        guard_test();
        emcy_test();
        ctrl_test();
        sdo_test();
        final_report();
    end
endmodule // gns_supervisor_tb_top
`default_nettype wire
